// *** verilog/dcf_pkg.sv ***
// Purpose: shared constants and carriers for the converter digital control block
// Assumes: 50 MHz mclk, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
`default_nettype none
package dcf_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DATA = 8'h00;   // +ch: data write
    localparam logic [7:0] OFF_GAIN = 8'h04;   // +ch: gain coefficient
    localparam logic [7:0] OFF_OFFS = 8'h08;   // +ch: offset coefficient
    localparam logic [7:0] OFF_CLRC = 8'h0C;   // +ch: clear code
    localparam logic [7:0] OFF_CCTL = 8'h10;   // +ch: channel control
    localparam logic [7:0] OFF_MAIN = 8'h14;   // main control
    localparam logic [7:0] OFF_SOFT = 8'h15;   // software register
    localparam logic [7:0] OFF_STAT = 8'h16;   // status
    localparam logic [7:0] OFF_CODE = 8'h18;   // +ch: stored code readback
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CCTL_CLR_BIT = 0;     // channel_clear_permit
    localparam int CCTL_RSET_BIT = 1;    // external current-set resistor
    localparam int MAIN_ECHO_BIT = 0;    // status_echo_enable
    localparam int MAIN_WDEN_BIT = 1;    // watchdog enable
    localparam int MAIN_WDSEL_LSB = 2;   // 2-bit timeout select
    localparam int SOFT_CRC_BIT = 12;    // crc_frame_check enable
    localparam int STAT_PERR_BIT = 0;    // packet error
    localparam int STAT_CRCON_BIT = 1;   // crc check enabled (read only)
    localparam int STAT_ALERT_BIT = 2;   // watchdog alert
    // ------------------------------------------------------------
    // reset values and fixed constants
    // ------------------------------------------------------------
    localparam logic [15:0] GAIN_RST = 16'hFFFF;
    localparam logic [15:0] OFFS_RST = 16'h8000;
    localparam logic [15:0] HALF_SCALE = 16'h8000;
    localparam logic [15:0] KICK_VALUE = 16'h0195;
    localparam logic [7:0] CRC_POLY = 8'h07;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int WD_MS0 = 5;
    localparam int WD_MS1 = 10;
    localparam int WD_MS2 = 100;
    localparam int WD_MS3 = 200;
    localparam logic [23:0] WD_CYC0 = 24'(WD_MS0 * CLK_MHZ * 1000);
    localparam logic [23:0] WD_CYC1 = 24'(WD_MS1 * CLK_MHZ * 1000);
    localparam logic [23:0] WD_CYC2 = 24'(WD_MS2 * CLK_MHZ * 1000);
    localparam logic [23:0] WD_CYC3 = 24'(WD_MS3 * CLK_MHZ * 1000);
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dcf_req_t;
    typedef enum logic [1:0] {CS_IDLE, CS_MUL, CS_ADD, CS_STORE} dcf_cstate_t;
endpackage : dcf_pkg
`default_nettype wire

// *** verilog/dcf_ctrl.sv ***
// Purpose: gain/offset correction, clear, crc check, echo and watchdog
// Assumes: register port in place of the serial shift logic
// Notes: frames arrive as 32-bit words; crc byte sits in bits 7:0
//
// Overview of operation
// R01: per channel 16-bit gain and offset registers
// R02: code = d*(m+1)/2^16 + c - 2^15
// R03: gain resets all ones, offset half scale
// R04: one multiplier and adder shared by channels
// R05: coefficient writes wait for next data write
// R06: host calibrates gain before offset
// R07: echo enable shifts status out on writes
// R08: echo off at reset; blocks other readback
// R09: shared output lines need distinct addresses
// R10: clear rising edge loads clear codes
// R11: only clear permitted channels respond
// R12: cleared channels hold until new data
// R13: host appends crc-8 poly 0x07
// R14: crc enable bit 12 needs 32-bit frame
// R15: bad crc drops write, fault low, flag
// R16: status read clears error, releases fault
// R17: host avoids both address straps low
// R18: watchdog alerts without key write in time
// R19: watchdog enable and timeout in main
// R20: alert is push-pull active high
// R21: channel control selects external resistor
// R22: crc also appended to read data
// R23: status shows crc check enabled
// R24: packet error drives fault low
// R25: channels corrected one at a time
`default_nettype none
module dcf_ctrl
(
    input wire logic mclk,
    input wire logic rst,
    input wire dcf_pkg::dcf_req_t req,        // address, data, strobes
    input wire logic clear_in,                // clear input, active high
    input wire logic [1:0] hw_address,        // hw_address_bit1/0 straps
    output logic [31:0] rdata,                // read data, next cycle
    output logic serial_data_out_en,          // echo drive window
    output logic [15:0] serial_data_out,      // echoed status word
    output logic fault_n,                     // fault, active low
    output logic alert,                       // watchdog alert
    output logic [3:0] rset_ext,              // external resistor select
    output logic [63:0] dac_code              // four stored codes
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] gain [4];       // gain coefficients
    logic [15:0] offs [4];       // offset coefficients
    logic [15:0] clrc [4];       // clear codes
    logic [15:0] data [4];       // latest input data
    logic [15:0] code [4];       // stored channel codes
    logic [1:0] cctl [4];        // channel control bits
    logic [3:0] pend;            // channels awaiting correction
    logic [15:0] main_reg;       // main control
    logic [15:0] soft_reg;       // software register
    logic perr;                  // packet error flag
    logic clr_d;                 // last clear level
    dcf_pkg::dcf_cstate_t cst;   // correction sequencer
    logic [1:0] cch;             // channel under correction
    logic [32:0] prod;           // multiplier result
    logic [23:0] wd_cnt;         // watchdog count
    logic [23:0] wd_lim;         // selected timeout
    logic crc_on;
    logic [7:0] rx_crc;
    logic crc_ok;
    logic wr_ok;
    logic [7:0] wa;
    logic [15:0] wd16;
    logic clr_rise;
    logic stat_rd;
    logic [15:0] status;
    logic wd_kick;               // key value written this cycle

    // crc-8 over a 24-bit payload, msb first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
        begin
            if (c[7] ^ d[i])
                c = (c << 1) ^ dcf_pkg::CRC_POLY;
            else
                c = c << 1;
        end
        return c;
    endfunction : crc8

    // ------------------------------------------------------------
    // frame check
    // ------------------------------------------------------------
    // with crc on the payload shifts up one byte, so decode from there
    assign crc_on = soft_reg[dcf_pkg::SOFT_CRC_BIT];
    assign wa = crc_on ? req.wdata[31:24] : req.addr;
    assign wd16 = crc_on ? req.wdata[23:8] : req.wdata[15:0];
    assign rx_crc = crc8({wa, wd16});
    assign crc_ok = !crc_on || (rx_crc == req.wdata[7:0]);          // R14
    assign wr_ok = req.wr && crc_ok;                                // R15
    assign clr_rise = clear_in && !clr_d;                           // R10
    assign stat_rd = req.rd && req.addr == dcf_pkg::OFF_STAT;
    assign status = {13'h0, alert, crc_on, perr};                   // R23

    // packet error flag; a new error wins over the read-clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            perr <= 1'b0;
        else if (req.wr && !crc_ok)
            perr <= 1'b1;                                           // R15
        else if (stat_rd)
            perr <= 1'b0;                                           // R16
    end

    // fault only reflects the packet error in this block
    always_ff @(posedge mclk)
    begin
        if (rst)
            fault_n <= 1'b1;
        else
            fault_n <= !((req.wr && !crc_ok) || (perr && !stat_rd)); // R24
    end

    // ------------------------------------------------------------
    // coefficient and control registers
    // ------------------------------------------------------------
    // coefficient writes only store; outputs move on data writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                gain[i] <= dcf_pkg::GAIN_RST;                       // R03
                offs[i] <= dcf_pkg::OFFS_RST;                       // R03
                clrc[i] <= 16'h0000;
                cctl[i] <= 2'h0;
                data[i] <= 16'h0000;
            end
            main_reg <= 16'h0000;                                   // R08
            soft_reg <= 16'h0000;
        end
        else if (wr_ok)
        begin
            unique case (wa[7:2])
                dcf_pkg::OFF_GAIN[7:2]: gain[wa[1:0]] <= wd16;       // R01
                dcf_pkg::OFF_OFFS[7:2]: offs[wa[1:0]] <= wd16;       // R05
                dcf_pkg::OFF_CLRC[7:2]: clrc[wa[1:0]] <= wd16;
                dcf_pkg::OFF_CCTL[7:2]: cctl[wa[1:0]] <= wd16[1:0];  // R21
                dcf_pkg::OFF_DATA[7:2]: data[wa[1:0]] <= wd16;
                default:
                begin
                    if (wa == dcf_pkg::OFF_MAIN)
                        main_reg <= wd16;                           // R19
                    else if (wa == dcf_pkg::OFF_SOFT)
                        soft_reg <= wd16;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shared correction datapath
    // ------------------------------------------------------------
    // pending bits: set on data write (set wins), cleared at store
    always_ff @(posedge mclk)
    begin
        if (rst)
            pend <= 4'h0;
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_ok && wa == dcf_pkg::OFF_DATA + 8'(i))
                    pend[i] <= 1'b1;                                // R05
                else if (cst == dcf_pkg::CS_STORE && cch == 2'(i))
                    pend[i] <= 1'b0;
            end
        end
    end

    // one channel at a time through one multiplier and one adder
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cst <= dcf_pkg::CS_IDLE;
            cch <= 2'h0;
            prod <= 33'h0;
        end
        else
        begin
            unique case (cst)
                dcf_pkg::CS_IDLE:
                begin
                    // lowest pending channel first
                    for (int i = 3; i >= 0; i--)
                    begin
                        if (pend[i])
                        begin
                            cch <= 2'(i);
                            cst <= dcf_pkg::CS_MUL;                 // R25
                        end
                    end
                end
                dcf_pkg::CS_MUL:
                begin
                    prod <= data[cch] * ({1'b0, gain[cch]} + 17'h1); // R04
                    cst <= dcf_pkg::CS_ADD;
                end
                dcf_pkg::CS_ADD: cst <= dcf_pkg::CS_STORE;
                dcf_pkg::CS_STORE: cst <= dcf_pkg::CS_IDLE;
            endcase
        end
    end

    // stored codes: correction result, or clear code on clear edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            clr_d <= 1'b0;
            for (int i = 0; i < 4; i++)
                code[i] <= 16'h0000;
        end
        else
        begin
            clr_d <= clear_in;
            if (cst == dcf_pkg::CS_STORE)
                // modulo 16 bits; no saturation on overflow
                code[cch] <= 16'(prod[31:16] + offs[cch] - dcf_pkg::HALF_SCALE); // R02
            for (int i = 0; i < 4; i++)
            begin
                // edge, not level: held code stays until next data
                if (clr_rise && cctl[i][dcf_pkg::CCTL_CLR_BIT])
                    code[i] <= clrc[i];                             // R10 R11 R12
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dac_code <= 64'h0;
            rset_ext <= 4'h0;
        end
        else
        begin
            dac_code <= {code[3], code[2], code[1], code[0]};
            for (int i = 0; i < 4; i++)
                rset_ext[i] <= cctl[i][dcf_pkg::CCTL_RSET_BIT];    // R21
        end
    end

    // ------------------------------------------------------------
    // readback and status echo
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata <= 32'h0;
            serial_data_out <= 16'h0000;
            serial_data_out_en <= 1'b0;
        end
        else
        begin
            serial_data_out_en <= req.wr && main_reg[dcf_pkg::MAIN_ECHO_BIT]; // R07
            serial_data_out <= status;
            if (!req.rd)
                rdata <= 32'h0;
            else
            begin
                logic [15:0] v;
                v = 16'h0000;
                if (main_reg[dcf_pkg::MAIN_ECHO_BIT] || req.addr == dcf_pkg::OFF_STAT)
                    v = status;                                     // R08
                else if (req.addr[7:2] == dcf_pkg::OFF_GAIN[7:2])
                    v = gain[req.addr[1:0]];
                else if (req.addr[7:2] == dcf_pkg::OFF_OFFS[7:2])
                    v = offs[req.addr[1:0]];
                else if (req.addr[7:2] == dcf_pkg::OFF_CLRC[7:2])
                    v = clrc[req.addr[1:0]];
                else if (req.addr[7:2] == dcf_pkg::OFF_CCTL[7:2])
                    v = {14'h0, cctl[req.addr[1:0]]};
                else if (req.addr[7:2] == dcf_pkg::OFF_CODE[7:2])
                    v = code[req.addr[1:0]];
                else if (req.addr == dcf_pkg::OFF_MAIN)
                    v = main_reg;
                else if (req.addr == dcf_pkg::OFF_SOFT)
                    v = soft_reg;
                // readback carries its own crc when checking is on
                rdata <= crc_on ? {req.addr, v, crc8({req.addr, v})} : {16'h0, v}; // R22
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (main_reg[dcf_pkg::MAIN_WDSEL_LSB +: 2])
            2'h0: wd_lim = dcf_pkg::WD_CYC0;
            2'h1: wd_lim = dcf_pkg::WD_CYC1;
            2'h2: wd_lim = dcf_pkg::WD_CYC2;
            2'h3: wd_lim = dcf_pkg::WD_CYC3;
        endcase
    end

    // only a frame that passed its check may kick the watchdog
    assign wd_kick = wr_ok && wa == dcf_pkg::OFF_SOFT && wd16 == dcf_pkg::KICK_VALUE;
    // key write restarts the count; alert is a plain driven level
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wd_cnt <= 24'h0;
            alert <= 1'b0;
        end
        else if (!main_reg[dcf_pkg::MAIN_WDEN_BIT])
        begin
            wd_cnt <= 24'h0;
            alert <= 1'b0;
        end
        else if (wd_kick)
        begin
            wd_cnt <= 24'h0;
            alert <= 1'b0;                                          // R18
        end
        else if (wd_cnt >= wd_lim - 24'h1)
            alert <= 1'b1;                                          // R18 R20
        else
            wd_cnt <= wd_cnt + 24'h1;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_bad_crc_fault: assert property (@(posedge mclk) disable iff (rst) // R15
        (req.wr && !crc_ok) |=> !fault_n && perr)
        else $error("bad frame did not raise fault");
    a_stat_clears_err: assert property (@(posedge mclk) disable iff (rst) // R16
        (stat_rd && !req.wr) |=> !perr && fault_n)
        else $error("status read did not clear error");
    a_corr_latency: assert property (@(posedge mclk) disable iff (rst) // R25
        (cst == dcf_pkg::CS_IDLE && pend != 4'h0) |=> cst == dcf_pkg::CS_MUL ##2
        cst == dcf_pkg::CS_STORE)
        else $error("correction sequence broken");
    a_clear_load: assert property (@(posedge mclk) disable iff (rst) // R10
        (clr_rise && cctl[1][dcf_pkg::CCTL_CLR_BIT]) |=> code[1] == $past(clrc[1]))
        else $error("clear code not loaded");
    a_clear_ignored: assert property (@(posedge mclk) disable iff (rst) // R11
        (!cctl[0][dcf_pkg::CCTL_CLR_BIT] && !(cst == dcf_pkg::CS_STORE && cch == 2'h0))
        |=> $stable(code[0]))
        else $error("unpermitted channel changed");
    a_echo_win: assert property (@(posedge mclk) disable iff (rst) // R07
        (req.wr && main_reg[0]) |=> serial_data_out_en)
        else $error("echo missing on write");
    a_wd_quiet: assert property (@(posedge mclk) disable iff (rst) // R18
        !main_reg[1] |=> !alert)
        else $error("alert while watchdog off");
    a_wd_count: assert property (@(posedge mclk) disable iff (rst) // R18
        (main_reg[dcf_pkg::MAIN_WDEN_BIT] && !wd_kick && wd_cnt < wd_lim - 24'h1)
        |=> wd_cnt == $past(wd_cnt) + 24'h1)
        else $error("watchdog count did not advance");
    a_wd_fire: assert property (@(posedge mclk) disable iff (rst) // R18
        (main_reg[dcf_pkg::MAIN_WDEN_BIT] && !wd_kick && wd_cnt >= wd_lim - 24'h1)
        |=> alert)
        else $error("watchdog did not raise alert");
    a_crc_flag: assert property (@(posedge mclk) disable iff (rst) // R23
        stat_rd |=> ($past(crc_on) ? rdata[9] : !rdata[1]))
        else $error("crc enable not reported");
endmodule : dcf_ctrl
`default_nettype wire

// *** tb/dcf_host.sv ***
// Purpose: host model driving the register port of dcf_ctrl
// Assumes: one request per call, strobe dropped on the edge after it is taken
// Notes: crc_mode switches between plain words and framed words
`default_nettype none
module dcf_host
(
    input wire logic mclk,
    input wire logic [31:0] rdata,
    output var dcf_pkg::dcf_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic crc_mode = 1'b0; // frames carry a check byte
    initial req = '0;
    // ------------------------------------------------------------
    // crc-8, msb first, init zero
    // ------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [23:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? dcf_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // one write; bad spoils the check byte so the device must drop it
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic bad = 1'b0);
        logic [23:0] f;
        f = {a, d};
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= crc_mode ? {f, crc8(f) ^ {7'h00, bad}} : {16'h0000, d};
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr
    // one read; data taken in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd
endmodule : dcf_host
`default_nettype wire

// *** tb/test_dcf_ctrl.sv ***
// Purpose: self-checking bench for dcf_ctrl
// Assumes: host model on the register port, 50 MHz mclk
// Notes: watchdog periods are too long to run out; only early alerts are caught
`default_nettype none
module test_dcf_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic clear_in = 1'b0;
    logic [1:0] hw_address = 2'b01; // straps not both low
    dcf_pkg::dcf_req_t req;
    logic [31:0] rdata;
    logic serial_data_out_en, fault_n, alert;
    logic [15:0] serial_data_out;
    logic [3:0] rset_ext;
    logic [63:0] dac_code;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] v; // last read word
    logic [15:0] e [4]; // expected channel codes
    dcf_ctrl dut (.mclk(mclk), .rst(rst), .req(req), .clear_in(clear_in),
        .hw_address(hw_address), .rdata(rdata), .serial_data_out_en(serial_data_out_en),
        .serial_data_out(serial_data_out), .fault_n(fault_n), .alert(alert),
        .rset_ext(rset_ext), .dac_code(dac_code));
    dcf_host u_host (.mclk(mclk), .rdata(rdata), .req(req));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n = 12);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    function automatic logic [31:0] get(input int ch);
        return {16'h0000, dac_code[16*ch +: 16]};
    endfunction : get
    // reference correction, worked out independently
    function automatic logic [15:0] expc(input logic [15:0] d, m, c);
        logic [32:0] p;
        p = {17'h0, d} * ({17'h0, m} + 33'h1);
        return 16'(p[31:16] + c - dcf_pkg::HALF_SCALE);
    endfunction : expc
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1 chk({fault_n, alert, rset_ext}, 32'h20);
        u_host.wr(8'(dcf_pkg::OFF_DATA + 2), 16'h1234);
        #1 chk(serial_data_out_en, 32'h0);
        settle();
        chk(get(2), 32'h1234);
        u_host.rd(8'(dcf_pkg::OFF_GAIN + 1), v);
        chk(v, 32'h0000FFFF);
        u_host.rd(8'(dcf_pkg::OFF_OFFS + 1), v);
        chk(v, 32'h00008000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_coeff();
        u_host.wr(dcf_pkg::OFF_GAIN, 16'h7FFF);
        u_host.wr(dcf_pkg::OFF_OFFS, 16'h8010);
        settle();
        chk(get(0), 32'h0);
        u_host.wr(dcf_pkg::OFF_DATA, 16'h4000);
        settle();
        chk(get(0), 32'(expc(16'h4000, 16'h7FFF, 16'h8010)));
        $display("test coeff done");
    endtask : t_coeff
    // four channels queued behind one datapath
    task automatic t_share();
        for (int ch = 0; ch < 4; ch++)
        begin
            e[ch] = 16'h1111 * 16'(ch + 1);
            u_host.wr(8'(dcf_pkg::OFF_DATA + ch), e[ch]);
        end
        e[0] = expc(e[0], 16'h7FFF, 16'h8010);
        settle(30);
        for (int ch = 0; ch < 4; ch++)
            chk(get(ch), 32'(e[ch]));
        $display("test share done");
    endtask : t_share
    task automatic t_clear();
        u_host.wr(dcf_pkg::OFF_CLRC, 16'hAAAA);
        u_host.wr(8'(dcf_pkg::OFF_CLRC + 1), 16'h2222);
        u_host.wr(8'(dcf_pkg::OFF_CCTL + 1), 16'h0001);
        @(posedge mclk) clear_in <= 1'b1;
        settle();
        chk(get(1), 32'h2222);
        chk(get(0), 32'(e[0]));
        @(posedge mclk) clear_in <= 1'b0;
        settle();
        chk(get(1), 32'h2222);
        u_host.wr(8'(dcf_pkg::OFF_DATA + 1), 16'h0100);
        settle();
        chk(get(1), 32'h0100);
        $display("test clear done");
    endtask : t_clear
    task automatic t_crc();
        u_host.wr(dcf_pkg::OFF_SOFT, 16'h1000);
        u_host.crc_mode = 1'b1;
        u_host.rd(dcf_pkg::OFF_STAT, v);
        chk(v[23:8], 32'h0002);
        chk(v[7:0], 32'(u_host.crc8(v[31:8])));
        u_host.wr(8'(dcf_pkg::OFF_DATA + 2), 16'h0ABC);
        u_host.wr(8'(dcf_pkg::OFF_DATA + 2), 16'h0DEF, 1'b1);
        settle();
        chk(get(2), 32'h0ABC);
        chk(fault_n, 32'h0);
        u_host.rd(dcf_pkg::OFF_STAT, v);
        chk(v[23:8], 32'h0003);
        settle(2);
        chk(fault_n, 32'h1);
        u_host.rd(dcf_pkg::OFF_STAT, v);
        chk(v[23:8], 32'h0002);
        u_host.wr(dcf_pkg::OFF_SOFT, 16'h0000);
        u_host.crc_mode = 1'b0;
        $display("test crc done");
    endtask : t_crc
    task automatic t_echo();
        u_host.wr(dcf_pkg::OFF_MAIN, 16'h0001);
        u_host.wr(8'(dcf_pkg::OFF_DATA + 3), 16'h0777);
        #1 chk({serial_data_out_en, serial_data_out}, 32'h10000);
        settle();
        u_host.rd(8'(dcf_pkg::OFF_CODE + 3), v);
        chk(v, 32'h0);
        u_host.wr(dcf_pkg::OFF_MAIN, 16'h0000);
        u_host.rd(8'(dcf_pkg::OFF_CODE + 3), v);
        chk(v, 32'h0777);
        $display("test echo done");
    endtask : t_echo
    task automatic t_misc();
        u_host.wr(8'(dcf_pkg::OFF_CCTL + 3), 16'h0002);
        settle();
        chk(rset_ext, 32'h8);
        u_host.rd(8'hF0, v);
        chk(v, 32'h0);
        u_host.wr(dcf_pkg::OFF_MAIN, 16'h0002);
        settle(2000);
        chk(alert, 32'h0);
        u_host.wr(dcf_pkg::OFF_SOFT, dcf_pkg::KICK_VALUE);
        settle();
        chk(alert, 32'h0);
        u_host.wr(dcf_pkg::OFF_MAIN, 16'h000E);
        settle(200);
        chk(alert, 32'h0);
        u_host.wr(dcf_pkg::OFF_MAIN, 16'h0000);
        $display("test misc done");
    endtask : t_misc
    // ------------------------------------------------------------
    // clock, watchdog on the run, main sequence
    // ------------------------------------------------------------
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    // hang guard well above the roughly 2400 cycles of the run
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_coeff();
        t_share();
        t_clear();
        t_crc();
        t_echo();
        t_misc();
        tally_and_finish();
    end
endmodule : test_dcf_ctrl
`default_nettype wire
